// >>> include/nfh_pkg.sv
package nfh_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int COL_W = 11;
  localparam int ROW_W = 16;
  localparam int LEN_W = 12;
  localparam int FIFO_DEPTH = 8;
  localparam logic [LEN_W-1:0] PAGE_BYTES = 12'h840;
  localparam logic [2:0] ADDR_CYCLES = 3'h4;
  localparam logic [2:0] ROW_FIRST = 3'h2;
  localparam logic [2:0] COL_CYCLES = 3'h2;

  // ----------------------------------------------------------------
  // strobe timing, ns, and derived cycles at 40 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_WE_LO_NS = 25;
  localparam int T_WE_HI_NS = 25;
  localparam int T_RD_LO_NS = 50;
  localparam int T_RD_HI_NS = 25;
  localparam int T_BUSY_NS = 100;
  // least times, so round up; never below one cycle
  localparam int WE_LO_N = (T_WE_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_HI_N = (T_WE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_LO_N = (T_RD_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_HI_N = (T_RD_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_N = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WE_LO_CYC = 8'((WE_LO_N < 1) ? 1 : WE_LO_N);
  localparam logic [7:0] WE_HI_CYC = 8'((WE_HI_N < 1) ? 1 : WE_HI_N);
  localparam logic [7:0] RD_LO_CYC = 8'((RD_LO_N < 1) ? 1 : RD_LO_N);
  localparam logic [7:0] RD_HI_CYC = 8'((RD_HI_N < 1) ? 1 : RD_HI_N);
  localparam logic [7:0] BUSY_CYC = 8'((BUSY_N < 1) ? 1 : BUSY_N);

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] C_READ = 8'h00;
  localparam logic [7:0] C_READ_GO = 8'h30;
  localparam logic [7:0] C_READ_CB_GO = 8'h35;
  localparam logic [7:0] C_IDENT = 8'h90;
  localparam logic [7:0] C_RESET = 8'hFF;
  localparam logic [7:0] C_PROG = 8'h80;
  localparam logic [7:0] C_PROG_GO = 8'h10;
  localparam logic [7:0] C_CACHE_GO = 8'h15;
  localparam logic [7:0] C_CB_PROG = 8'h85;
  localparam logic [7:0] C_ERASE = 8'h60;
  localparam logic [7:0] C_ERASE_GO = 8'hD0;
  localparam logic [7:0] C_RAND_OUT = 8'h05;
  localparam logic [7:0] C_RAND_OUT_GO = 8'hE0;
  localparam logic [7:0] C_STATUS = 8'h70;
  localparam logic [7:0] IDENT_ADDR = 8'h00;

  typedef enum logic [3:0] {
    OP_READ, OP_READ_CB, OP_READ_ID, OP_RESET, OP_PROG, OP_CACHE,
    OP_CB_PROG, OP_ERASE, OP_RAND_IN, OP_RAND_OUT, OP_STATUS, OP_AUTO
  } nfh_op_t;

endpackage

// >>> include/nfh_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nfh_fifo_if #(parameter int W = 8) ();
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport ctl (output in_valid, in_data, out_ready,
               input in_ready, out_valid, out_data);
endinterface // nfh_fifo_if
`default_nettype wire

// >>> design/nfh_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module nfh_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  nfh_fifo_if.fifo f
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(D);
  localparam logic [AW-1:0] LAST = AW'(D - 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire push = f.in_valid && f.in_ready;
  wire pop = f.out_valid && f.out_ready;

  assign f.in_ready = (cnt != FULL);
  assign f.out_valid = (cnt != '0);
  assign f.out_data = mem[rp];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= f.in_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == LAST) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == LAST) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // nfh_fifo
`default_nettype wire

// >>> design/nfh_host.sv
`timescale 1ns/1ps
`default_nettype none
module nfh_host #(
  parameter logic POWERON_READ = 1'b1
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire nfh_pkg::nfh_op_t CMD_OP_I,
  input wire logic [nfh_pkg::COL_W-1:0] CMD_COL_I,
  input wire logic [nfh_pkg::ROW_W-1:0] CMD_ROW_I,
  input wire logic [nfh_pkg::LEN_W-1:0] CMD_LEN_I,
  input wire logic WR_VALID_I,
  output logic WR_READY_O,
  input wire logic [nfh_pkg::DATA_W-1:0] WR_DATA_I,
  output logic RD_VALID_O,
  output logic [nfh_pkg::DATA_W-1:0] RD_DATA_O,
  output logic DONE_O,
  output logic ERR_O,
  output logic BUSY_O,
  output logic NAND_CE_N_O,
  output logic NAND_CLE_O,
  output logic NAND_ALE_O,
  output logic NAND_WE_N_O,
  output logic NAND_READ_STROBE_N_O,
  output logic NAND_WP_N_O,
  output logic NAND_PRE_O,
  input wire logic NAND_RB_I,
  input wire logic [nfh_pkg::DATA_W-1:0] NAND_IO_I,
  output logic [nfh_pkg::DATA_W-1:0] NAND_IO_O,
  output logic NAND_IO_OE_N_O
);
  import nfh_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WAIT_WB, S_WAIT_RB,
    S_RDATA, S_DONE
  } nfh_state_t;

  nfh_state_t state;
  nfh_op_t op;
  logic [COL_W-1:0] col;
  logic [ROW_W-1:0] row;
  logic [LEN_W-1:0] cnt;
  logic [2:0] aidx;
  logic [7:0] tmr;
  logic act;
  logic lo_ph;
  logic we_n;
  logic re_n;
  logic wp_n;
  logic err;
  logic done;
  logic rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] io_out;

  nfh_fifo_if #(.W(DATA_W)) wq ();

  nfh_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_wq (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .f(wq.fifo)
  );

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------
  wire is_read = (op == OP_READ) || (op == OP_READ_CB);
  wire is_prog = (op == OP_PROG) || (op == OP_CACHE);
  wire wr_dir = is_prog || (op == OP_CB_PROG) || (op == OP_RAND_IN);
  wire rd_dir = (op == OP_READ) || (op == OP_READ_ID) ||
                (op == OP_RAND_OUT) || (op == OP_STATUS) || (op == OP_AUTO);
  wire has_cmd2 = is_read || wr_dir && (op != OP_RAND_IN) ||
                  (op == OP_ERASE) || (op == OP_RAND_OUT);
  // array operations and reset pull ready/busy low after their last command
  wire needs_rb = is_read || is_prog || (op == OP_CB_PROG) ||
                  (op == OP_ERASE) || (op == OP_RESET);

  // only codes of the defined set can be produced here
  wire [7:0] cmd1 =
    is_read ? C_READ :
    (op == OP_READ_ID) ? C_IDENT :
    (op == OP_RESET) ? C_RESET :
    is_prog ? C_PROG :
    (op == OP_CB_PROG || op == OP_RAND_IN) ? C_CB_PROG :
    (op == OP_ERASE) ? C_ERASE :
    (op == OP_RAND_OUT) ? C_RAND_OUT : C_STATUS;
  wire [7:0] cmd2 =
    (op == OP_READ) ? C_READ_GO :
    (op == OP_READ_CB) ? C_READ_CB_GO :
    (op == OP_CACHE) ? C_CACHE_GO :
    (op == OP_ERASE) ? C_ERASE_GO :
    (op == OP_RAND_OUT) ? C_RAND_OUT_GO : C_PROG_GO;

  // erase skips the column cycles; random ops send column only
  wire [2:0] addr_first = (op == OP_ERASE) ? ROW_FIRST : 3'h0;
  wire [2:0] addr_end =
    (op == OP_READ_ID) ? 3'h1 :
    (op == OP_RAND_IN || op == OP_RAND_OUT) ? COL_CYCLES :
    (op == OP_RESET || op == OP_STATUS || op == OP_AUTO) ? 3'h0 :
    ADDR_CYCLES;
  wire has_addr = (addr_first != addr_end);

  // column then row, unused high bits of cycle two held low
  wire [7:0] addr_byte =
    (op == OP_READ_ID) ? IDENT_ADDR :
    (aidx == 3'h0) ? col[7:0] :
    (aidx == 3'h1) ? {5'h00, col[10:8]} :
    (aidx == 3'h2) ? row[7:0] : row[15:8];

  wire wdata_go = wr_dir && (cnt != '0);
  wire rdata_go = rd_dir && (cnt != '0);
  wire last_addr = ((aidx + 3'h1) == addr_end);
  wire last_byte = (cnt == LEN_W'(1));
  wire op_bad = (op > OP_AUTO);

  nfh_state_t after_cmd2;
  nfh_state_t after_wdata;
  nfh_state_t after_addr;
  nfh_state_t after_cmd1;
  assign after_cmd2 = needs_rb ? S_WAIT_WB : rdata_go ? S_RDATA : S_DONE;
  assign after_wdata = has_cmd2 ? S_CMD2 : S_DONE;
  assign after_addr = wdata_go ? S_WDATA :
                      has_cmd2 ? S_CMD2 : after_cmd2;
  assign after_cmd1 = has_addr ? S_ADDR : after_addr;

  // ----------------------------------------------------------------
  // acceptance
  // ----------------------------------------------------------------
  // while the device is busy only reset and status may go out
  wire busy_ok = NAND_RB_I || (CMD_OP_I == OP_RESET) ||
                 (CMD_OP_I == OP_STATUS);
  wire op_ok = (CMD_OP_I <= OP_AUTO);
  wire take = CMD_VALID_I && CMD_READY_O;
  wire [LEN_W-1:0] len_cl = (CMD_LEN_I > PAGE_BYTES) ? PAGE_BYTES :
                            CMD_LEN_I;
  wire [LEN_W-1:0] len_in = (CMD_OP_I == OP_STATUS) ? LEN_W'(1) : len_cl;

  // ----------------------------------------------------------------
  // strobe engine
  // ----------------------------------------------------------------
  wire wr_state = (state == S_CMD1) || (state == S_ADDR) ||
                  (state == S_WDATA) || (state == S_CMD2);
  wire start_wr = wr_state && !act &&
                  ((state != S_WDATA) || wq.out_valid);
  wire start_rd = (state == S_RDATA) && !act;
  wire lo_end = act && lo_ph && (tmr == 8'h00);
  wire hi_end = act && !lo_ph && (tmr == 8'h00);
  wire [7:0] wr_value = (state == S_CMD1) ? cmd1 :
                        (state == S_CMD2) ? cmd2 :
                        (state == S_ADDR) ? addr_byte : wq.out_data;

  assign wq.in_valid = WR_VALID_I;
  assign wq.in_data = WR_DATA_I;
  assign wq.out_ready = start_wr && (state == S_WDATA);
  assign WR_READY_O = wq.in_ready;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      act <= 1'b0;
      lo_ph <= 1'b0;
      tmr <= 8'h00;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 8'h00;
    end else if (start_wr) begin
      act <= 1'b1;
      lo_ph <= 1'b1;
      tmr <= WE_LO_CYC - 8'h01;
      we_n <= 1'b0;
      io_out <= wr_value;
    end else if (start_rd) begin
      act <= 1'b1;
      lo_ph <= 1'b1;
      tmr <= RD_LO_CYC - 8'h01;
      re_n <= 1'b0;
    end else if (lo_end) begin
      // rising edge of the write strobe latches the value
      lo_ph <= 1'b0;
      tmr <= (state == S_RDATA) ? RD_HI_CYC - 8'h01 : WE_HI_CYC - 8'h01;
      we_n <= 1'b1;
      re_n <= 1'b1;
    end else if (hi_end) begin
      act <= 1'b0;
      // busy wait counts from the last strobe, not from idle
      tmr <= BUSY_CYC - 8'h01;
    end else if (state == S_IDLE || state == S_WAIT_WB) begin
      tmr <= (state == S_IDLE) ? BUSY_CYC - 8'h01 : tmr - 8'h01;
    end else if (act) begin
      tmr <= tmr - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      state <= S_IDLE;
      op <= OP_STATUS;
      col <= '0;
      row <= '0;
      cnt <= '0;
      aidx <= 3'h0;
      done <= 1'b0;
      err <= 1'b0;
    end else begin
      done <= 1'b0;
      err <= 1'b0;
      case (state)
        S_IDLE: begin
          if (take) begin
            op <= CMD_OP_I;
            col <= CMD_COL_I;
            row <= CMD_ROW_I;
            cnt <= len_in;
            aidx <= (CMD_OP_I == OP_ERASE) ? ROW_FIRST : 3'h0;
            if (!op_ok) begin
              state <= S_DONE;
            end else if (CMD_OP_I == OP_AUTO) begin
              // stream the first page with no command ahead
              state <= (len_in != '0) ? S_RDATA : S_DONE;
            end else begin
              state <= S_CMD1;
            end
          end
        end
        S_CMD1: begin
          if (hi_end) begin
            state <= after_cmd1;
          end
        end
        S_ADDR: begin
          if (hi_end) begin
            aidx <= aidx + 3'h1;
            if (last_addr) begin
              state <= after_addr;
            end
          end
        end
        S_WDATA: begin
          if (hi_end) begin
            cnt <= cnt - LEN_W'(1);
            if (last_byte) begin
              state <= after_wdata;
            end
          end
        end
        S_CMD2: begin
          if (hi_end) begin
            state <= after_cmd2;
          end
        end
        S_WAIT_WB: begin
          // give the device time to pull ready/busy low
          if (tmr == 8'h00) begin
            state <= S_WAIT_RB;
          end
        end
        S_WAIT_RB: begin
          if (NAND_RB_I) begin
            state <= rdata_go ? S_RDATA : S_DONE;
          end
        end
        S_RDATA: begin
          if (hi_end) begin
            cnt <= cnt - LEN_W'(1);
            if (last_byte) begin
              state <= S_DONE;
            end
          end
        end
        S_DONE: begin
          done <= 1'b1;
          err <= op_bad;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read capture and pins
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      wp_n <= 1'b0;
    end else begin
      // write protect stays on through reset, released after
      wp_n <= 1'b1;
      rd_valid <= (state == S_RDATA) && lo_end;
      if ((state == S_RDATA) && lo_end) begin
        rd_data <= NAND_IO_I;
      end
    end
  end

  assign CMD_READY_O = (state == S_IDLE) && busy_ok;
  assign BUSY_O = (state != S_IDLE);
  assign DONE_O = done;
  assign ERR_O = err;
  assign RD_VALID_O = rd_valid;
  assign RD_DATA_O = rd_data;
  assign NAND_CE_N_O = (state == S_IDLE) || (state == S_DONE);
  assign NAND_CLE_O = (state == S_CMD1) || (state == S_CMD2);
  assign NAND_ALE_O = (state == S_ADDR);
  assign NAND_WE_N_O = we_n;
  assign NAND_READ_STROBE_N_O = re_n;
  assign NAND_WP_N_O = wp_n;
  assign NAND_PRE_O = POWERON_READ;
  assign NAND_IO_O = io_out;
  assign NAND_IO_OE_N_O = !wr_state;
endmodule // nfh_host
`default_nettype wire

// >>> verification/nfh_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module nfh_host_asserts (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CMD_READY_O,
  input wire nfh_pkg::nfh_op_t CMD_OP_I,
  input wire logic DONE_O,
  input wire logic ERR_O,
  input wire logic BUSY_O,
  input wire logic RD_VALID_O,
  input wire logic NAND_CE_N_O,
  input wire logic NAND_CLE_O,
  input wire logic NAND_ALE_O,
  input wire logic NAND_WE_N_O,
  input wire logic NAND_READ_STROBE_N_O,
  input wire logic NAND_RB_I,
  input wire logic [nfh_pkg::DATA_W-1:0] NAND_IO_O,
  input wire logic NAND_IO_OE_N_O
);
  import nfh_pkg::*;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // ------
  // bus cycle shape
  // ------
  property p_cle_ale; !(NAND_CLE_O && NAND_ALE_O); endproperty
  a_cle_ale: assert property (p_cle_ale) else $error("cle with ale");
  property p_we_ce;
    !NAND_WE_N_O |-> !NAND_CE_N_O && !NAND_IO_OE_N_O;
  endproperty
  a_we_ce: assert property (p_we_ce) else $error("write unselected");
  property p_we_hold;
    !NAND_WE_N_O |=> $stable(NAND_IO_O) && $stable(NAND_CLE_O)
      && $stable(NAND_ALE_O);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("bus moved");
  property p_re_idle;
    !NAND_READ_STROBE_N_O |-> NAND_WE_N_O && NAND_IO_OE_N_O;
  endproperty
  a_re_idle: assert property (p_re_idle) else $error("read clash");
  property p_rd_after; $rose(NAND_READ_STROBE_N_O) |-> ##[0:1] RD_VALID_O;
  endproperty
  a_rd_after: assert property (p_rd_after) else $error("no byte");
  property p_cmd_code;
    NAND_CLE_O && !NAND_WE_N_O |-> NAND_IO_O inside {8'h00, 8'h30, 8'h35,
      8'h90, 8'hFF, 8'h80, 8'h10, 8'h15, 8'h85, 8'h60, 8'hD0, 8'h05,
      8'hE0, 8'h70};
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("bad code");
  // ------
  // request acceptance
  // ------
  property p_ready_busy;
    CMD_READY_O && !NAND_RB_I |-> CMD_OP_I inside {OP_RESET, OP_STATUS};
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("busy");
  property p_err_done; ERR_O |-> DONE_O; endproperty
  a_err_done: assert property (p_err_done) else $error("err alone");
  property p_done_end; $fell(BUSY_O) |-> DONE_O; endproperty
  a_done_end: assert property (p_done_end) else $error("no done");
  c_read: cover property (RD_VALID_O);
  c_err: cover property (ERR_O);
  c_busy_status: cover property (CMD_READY_O && !NAND_RB_I);
endmodule // nfh_host_asserts
bind nfh_host nfh_host_asserts chk_u (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CMD_READY_O(CMD_READY_O),
  .CMD_OP_I(CMD_OP_I), .DONE_O(DONE_O), .ERR_O(ERR_O), .BUSY_O(BUSY_O),
  .RD_VALID_O(RD_VALID_O), .NAND_CE_N_O(NAND_CE_N_O),
  .NAND_CLE_O(NAND_CLE_O), .NAND_ALE_O(NAND_ALE_O),
  .NAND_WE_N_O(NAND_WE_N_O), .NAND_READ_STROBE_N_O(NAND_READ_STROBE_N_O),
  .NAND_RB_I(NAND_RB_I), .NAND_IO_O(NAND_IO_O),
  .NAND_IO_OE_N_O(NAND_IO_OE_N_O));
`default_nettype wire

// >>> verification/nfh_nand_model.sv
`timescale 1ns/1ps
`default_nettype none
module nfh_nand_model (
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic rd_n_i,
  input wire logic hold_busy_i,
  input wire logic [7:0] io_i,
  output logic rb_o,
  output logic [7:0] io_o
);
  logic [9:0] log_q[$];
  logic [7:0] cmd;
  logic [7:0] dq;
  logic [10:0] col;
  logic [2:0] na;
  logic rdy;
  logic busy;
  assign busy = !rdy || hold_busy_i;
  assign rb_o = !busy;
  assign io_o = dq;
  initial begin
    rdy = 1'b1;
    cmd = 8'h00;
    col = 11'h000;
    na = 3'h0;
    dq = 8'h00;
  end
  // every write strobe under chip enable is logged so the bench sees the raw cycle order
  always @(posedge we_n_i) begin
    if (!ce_n_i) begin
      log_q.push_back({cle_i, ale_i, io_i});
      if (cle_i && (!busy || io_i == 8'hFF || io_i == 8'h70)) begin
        cmd = io_i;
        na = 3'h0;
        if (io_i inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0, 8'hFF}) begin
          rdy = 1'b0;
          rdy <= #250 1'b1;
        end
      end else if (ale_i) begin
        if (na == 3'h0 && cmd != 8'h60) col[7:0] = io_i;
        if (na == 3'h1 && cmd != 8'h60) col[10:8] = io_i[2:0];
        if (na < 3'h4) na = na + 3'h1;
      end
    end
  end
  always @(negedge rd_n_i) begin
    if (!ce_n_i) begin
      dq = (cmd == 8'h70) ? {1'b1, !busy, 6'h00} : col[7:0] ^ 8'h5A;
      if (cmd != 8'h70) col = col + 11'h001;
    end
  end
  // released bus must not look like held data
  always @(posedge rd_n_i) dq <= #5 ~dq;
endmodule // nfh_nand_model
`default_nettype wire

// >>> verification/nfh_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nfh_host_bench;
  import nfh_pkg::*;
  logic clk = 0, rst_n = 0, cmd_valid = 0, wr_valid = 0, hold_busy = 0;
  nfh_op_t cmd_op = OP_STATUS;
  logic [10:0] cmd_col = 0;
  logic [15:0] cmd_row = 0;
  logic [11:0] cmd_len = 0;
  logic [7:0] wr_data = 0, rd_data, io_o, mdl_io, io_bus;
  logic cmd_ready, wr_ready, rd_valid, done, err, busy, ce_n, cle, ale;
  logic we_n, rs_n, wp_n, pre, rb, io_oe_n, got_err;
  logic [7:0] rd_q[$];
  int fail_count = 0, compares = 0;
  always #12.5 clk = !clk;
  assign io_bus = io_oe_n ? mdl_io : io_o;
  nfh_host dut_u (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(cmd_valid),
    .CMD_READY_O(cmd_ready), .CMD_OP_I(cmd_op), .CMD_COL_I(cmd_col),
    .CMD_ROW_I(cmd_row), .CMD_LEN_I(cmd_len), .WR_VALID_I(wr_valid),
    .WR_READY_O(wr_ready), .WR_DATA_I(wr_data), .RD_VALID_O(rd_valid),
    .RD_DATA_O(rd_data), .DONE_O(done), .ERR_O(err), .BUSY_O(busy),
    .NAND_CE_N_O(ce_n), .NAND_CLE_O(cle), .NAND_ALE_O(ale),
    .NAND_WE_N_O(we_n), .NAND_READ_STROBE_N_O(rs_n), .NAND_WP_N_O(wp_n),
    .NAND_PRE_O(pre), .NAND_RB_I(rb), .NAND_IO_I(io_bus), .NAND_IO_O(io_o),
    .NAND_IO_OE_N_O(io_oe_n));
  nfh_nand_model mdl_u (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale),
    .we_n_i(we_n), .rd_n_i(rs_n), .hold_busy_i(hold_busy), .io_i(io_bus),
    .rb_o(rb), .io_o(mdl_io));
  // ------
  // shared tasks
  // ------
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b);
    wr_data = b;
    wr_valid = 1;
    #1;
    while (wr_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #2;
  endtask
  task automatic go(input nfh_op_t op, input logic [10:0] c,
      input logic [15:0] r, input logic [11:0] n);
    int k;
    k = 0;
    rd_q.delete();
    mdl_u.log_q.delete();
    cmd_op = op;
    cmd_col = c;
    cmd_row = r;
    cmd_len = n;
    cmd_valid = 1;
    #1;
    while (cmd_ready !== 1'b1 && k < 500) begin
      @(posedge clk);
      #3;
      k++;
    end
    @(posedge clk);
    #2 cmd_valid = 0;
    do begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      k++;
    end while (done !== 1'b1 && k < 3000);
    check(10'(done), 10'h001);
    got_err = err;
    #1;
  endtask
  task automatic seq_chk(input nfh_op_t op, input logic [10:0] c,
      input logic [15:0] r, input logic [7:0] d[$]);
    logic [7:0] a[4];
    logic [7:0] c1, c2;
    logic [1:0] lo;
    logic [2:0] n;
    logic two;
    logic [9:0] e[$];
    a = '{c[7:0], {5'h00, c[10:8]}, r[7:0], r[15:8]};
    case (op)
      OP_READ: {c1, lo, n, two, c2} = {8'h00, 2'h0, 3'h4, 1'h1, 8'h30};
      OP_READ_CB: {c1, lo, n, two, c2} = {8'h00, 2'h0, 3'h4, 1'h1, 8'h35};
      OP_READ_ID: {c1, lo, n, two, c2} = {8'h90, 2'h0, 3'h1, 1'h0, 8'h00};
      OP_RESET: {c1, lo, n, two, c2} = {8'hFF, 2'h0, 3'h0, 1'h0, 8'h00};
      OP_PROG: {c1, lo, n, two, c2} = {8'h80, 2'h0, 3'h4, 1'h1, 8'h10};
      OP_CACHE: {c1, lo, n, two, c2} = {8'h80, 2'h0, 3'h4, 1'h1, 8'h15};
      OP_CB_PROG: {c1, lo, n, two, c2} = {8'h85, 2'h0, 3'h4, 1'h1, 8'h10};
      OP_ERASE: {c1, lo, n, two, c2} = {8'h60, 2'h2, 3'h2, 1'h1, 8'hD0};
      OP_RAND_IN: {c1, lo, n, two, c2} = {8'h85, 2'h0, 3'h2, 1'h0, 8'h00};
      OP_RAND_OUT: {c1, lo, n, two, c2} = {8'h05, 2'h0, 3'h2, 1'h1, 8'hE0};
      default: {c1, lo, n, two, c2} = {8'h70, 2'h0, 3'h0, 1'h0, 8'h00};
    endcase
    e.push_back({2'h2, c1});
    for (int i = 0; i < n; i++) e.push_back({2'h1, a[lo + i]});
    foreach (d[i]) e.push_back({2'h0, d[i]});
    if (two) e.push_back({2'h2, c2});
    check(10'(mdl_u.log_q.size()), 10'(e.size()));
    foreach (e[i]) check(mdl_u.log_q[i], e[i]);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_auto;
    go(OP_AUTO, 11'h000, 16'h0000, 12'h002);
    check(10'(mdl_u.log_q.size()), 10'h000);
    check(rd_q[0], 10'h05A);
    check(rd_q[1], 10'h05B);
  endtask
  task automatic t_read;
    logic [7:0] d[$];
    go(OP_READ, 11'h5A3, 16'hBEEF, 12'h003);
    seq_chk(OP_READ, 11'h5A3, 16'hBEEF, d);
    check(10'(rd_q.size()), 10'h003);
    for (int i = 0; i < 3; i++) begin
      check(rd_q[i], (8'hA3 + 8'(i)) ^ 8'h5A);
    end
  endtask
  task automatic t_prog;
    logic [7:0] d[$];
    for (int i = 0; i < 8; i++) begin
      d.push_back(8'h11 + 8'(i));
      wr(d[i]);
    end
    wr_valid = 0;
    @(posedge clk);
    #2;
    check(wr_ready, 10'h000);
    d.push_back(8'h19);
    d.push_back(8'h1A);
    fork
      go(OP_PROG, 11'h7FF, 16'hFFFF, 12'h00A);
      begin
        repeat (80) @(posedge clk);
        #2;
        wr(8'h19);
        wr(8'h1A);
        wr_valid = 0;
      end
    join
    seq_chk(OP_PROG, 11'h7FF, 16'hFFFF, d);
  endtask
  task automatic t_ops;
    nfh_op_t ops[8];
    logic [7:0] d[$];
    logic [10:0] c;
    ops = '{OP_READ_CB, OP_READ_ID, OP_RESET, OP_CACHE, OP_CB_PROG,
            OP_ERASE, OP_RAND_IN, OP_RAND_OUT};
    foreach (ops[i]) begin
      d.delete();
      c = (ops[i] == OP_READ_ID) ? 11'h000 : 11'h3C5;
      if (ops[i] inside {OP_CACHE, OP_CB_PROG, OP_RAND_IN}) begin
        d.push_back(8'h77);
        wr(8'h77);
        wr_valid = 0;
      end
      go(ops[i], c, 16'h1234, 12'h001);
      seq_chk(ops[i], c, 16'h1234, d);
    end
  endtask
  task automatic t_busy;
    hold_busy = 1;
    cmd_op = OP_READ;
    @(posedge clk);
    #2;
    check(cmd_ready, 10'h000);
    cmd_op = OP_RESET;
    @(posedge clk);
    #2;
    check(cmd_ready, 10'h001);
    go(OP_STATUS, 11'h000, 16'h0000, 12'h005);
    check(10'(rd_q.size()), 10'h001);
    check(rd_q[0], 10'h080);
    hold_busy = 0;
    go(OP_STATUS, 11'h000, 16'h0000, 12'h001);
    check(rd_q[0], 10'h0C0);
  endtask
  task automatic t_err;
    go(nfh_op_t'(4'hF), 11'h000, 16'h0000, 12'h001);
    check(got_err, 10'h001);
    check(10'(mdl_u.log_q.size()), 10'h000);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #2;
    check(wp_n, 10'h000);
    check(ce_n, 10'h001);
    rst_n = 1;
    @(posedge clk);
    #2;
    check(wp_n, 10'h001);
    check(pre, 10'h001);
    t_auto();
    t_read();
    t_prog();
    t_ops();
    t_busy();
    t_err();
    results();
  end
  // whole run needs a few hundred cycles
  initial begin
    #1000000;
    fail_count++;
    results();
  end
endmodule // nfh_host_bench
`default_nettype wire
